// [inc/cca_pkg.sv]
// Behaviour
// RULE_01 - Each module keeps a sixteen-bit hold value split in high and low bytes.
// RULE_02 - Capture watches the module pin and accepts only enabled edges.
// RULE_03 - A valid capture copies both counter bytes into the module hold value.
// RULE_04 - Rising bit captures rising edges, falling bit falling, both capture either edge.
// RULE_05 - After a capture, interrupt when event flag and module interrupt enable are set.
// RULE_06 - Compare enable plus match bit make a sixteen-bit software timer.
// RULE_07 - Software timer match interrupts when event flag and module interrupt enable set.
// RULE_08 - Toggle, match and compare enable set: pin inverts on every match.
// RULE_09 - Modulator mode is active only with modulation and compare enable set.
// RULE_10 - Modulator output low while counter low byte below compare byte, else high.
// RULE_11 - Counter low byte wrapping to zero reloads compare low byte from high byte.
// RULE_12 - Each module duty cycle is set on its own compare byte alone.
// RULE_13 - All modules run from the one shared counter and its count source.
// RULE_14 - Source select: 00 clock/12, 01 clock/4, 10 timer 0 overflow, 11 external.
// RULE_15 - Shared counter runs only while the run bit is set.
// RULE_16 - Counter overflow sets its flag, interrupts if enabled; only software clears it.
// RULE_17 - Match or capture sets the module event flag, bits 0 to 4; software clears.
// RULE_18 - A module with all mode bits zero does nothing at all.
package cca_pkg;

  localparam int          NUM_MOD       = 5;
  // Register byte addresses
  localparam logic [4:0]  ADDR_MODE     = 5'h00;
  localparam logic [4:0]  ADDR_CTRL     = 5'h01;
  localparam logic [4:0]  ADDR_CNT_LO   = 5'h02;
  localparam logic [4:0]  ADDR_CNT_HI   = 5'h03;
  localparam logic [4:0]  ADDR_STAT     = 5'h04;
  localparam logic [4:0]  ADDR_CLR      = 5'h05;
  localparam logic [4:0]  ADDR_IEN      = 5'h06;
  localparam logic [4:0]  ADDR_MMODE    = 5'h08;
  localparam logic [4:0]  ADDR_HOLD     = 5'h10;
  // counter_mode_reg fields
  localparam int          IDLE_STOP_BIT = 7;
  localparam int          GUARD_EN_BIT  = 6;
  localparam int          SRC_HI_BIT    = 2;
  localparam int          SRC_LO_BIT    = 1;
  localparam int          OVF_IEN_BIT   = 0;
  localparam logic [7:0]  MODE_VALID    = 8'hC7;
  // counter_control_reg fields
  localparam int          OVF_FLAG_BIT  = 7;
  localparam int          RUN_BIT       = 6;
  // module_mode_reg fields
  localparam int          CMP_EN_BIT    = 6;
  localparam int          RISE_BIT      = 5;
  localparam int          FALL_BIT      = 4;
  localparam int          MATCH_BIT     = 3;
  localparam int          TOGGLE_BIT    = 2;
  localparam int          PWM_BIT       = 1;
  localparam int          MOD_IEN_BIT   = 0;
  localparam logic [7:0]  MMODE_VALID   = 8'h7F;
  // Status and enable layout: modules at 0..4, overflow above
  localparam int          STAT_OVF_BIT  = 5;
  // Reset values
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic [7:0]  MMODE_RST     = 8'h00;
  localparam logic [15:0] HOLD_RST      = 16'h0000;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [5:0]  IEN_RST       = 6'h00;
  localparam logic        PIN_RST       = 1'b1;
  // Prescaler terminal counts
  localparam logic [3:0]  DIV12_LAST    = 4'hB;
  localparam logic [1:0]  DIV4_LAST     = 2'h3;

  typedef enum logic [1:0] {
    SRC_OSC12 = 2'b00,
    SRC_OSC4  = 2'b01,
    SRC_T0OVF = 2'b10,
    SRC_EXT   = 2'b11
  } src_t;

endpackage

// [inc/cc_link_if.sv]
`timescale 1ns/1ps
// Ties one capture/compare unit to the shared counter and register file
interface cc_link_if;
  logic [7:0]  mode;
  logic [15:0] count;
  logic        fresh;
  logic        pin_in;
  logic        wr_lo;
  logic        wr_hi;
  logic [7:0]  wdata;
  logic [15:0] hold;
  logic        event_p;
  logic        pin_out;
  logic        drive;
  modport ctl  (output mode, count, fresh, pin_in, wr_lo, wr_hi, wdata,
                input  hold, event_p, pin_out, drive);
  modport unit (input  mode, count, fresh, pin_in, wr_lo, wr_hi, wdata,
                output hold, event_p, pin_out, drive);
endinterface

// [hdl/count_source.sv]
`timescale 1ns/1ps
module count_source
  import cca_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       run_i,
  input  wire logic       t0_ovf_i,
  input  wire logic       ext_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [3:0] div12;
    logic [1:0] div4;
    logic       ext_prev;
    logic       tick;
  } src_state_t;

  src_state_t st_r;
  src_state_t st_nxt;
  logic       hit;

  // Prescalers run free so a source switch needs no restart
  always_comb begin
    st_nxt          = st_r;
    st_nxt.div12    = (st_r.div12 == DIV12_LAST) ? 4'h0 : st_r.div12 + 4'h1;
    st_nxt.div4     = st_r.div4 + 2'h1;
    st_nxt.ext_prev = ext_i;
    unique case (src_t'(sel_i))
      SRC_OSC12: hit = (st_r.div12 == DIV12_LAST);   // RULE_14
      SRC_OSC4:  hit = (st_r.div4 == DIV4_LAST);     // RULE_14
      SRC_T0OVF: hit = t0_ovf_i;                     // RULE_14
      SRC_EXT:   hit = st_r.ext_prev & ~ext_i;       // RULE_14
    endcase
    st_nxt.tick     = hit & run_i;                   // RULE_15
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule

// [hdl/capture_compare_unit.sv]
`timescale 1ns/1ps
module capture_compare_unit
  import cca_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  cc_link_if.unit   lnk
);

  typedef struct packed {
    logic [15:0] hold;
    logic        pin_prev;
    logic        pin_out;
    logic        drive;
    logic        event_p;
  } unit_state_t;

  unit_state_t st_r;
  unit_state_t st_nxt;
  logic        rise;
  logic        fall;
  logic        cap_hit;
  logic        match;
  logic        pwm_on;
  logic        wrap;
  logic [7:0]  duty;

  // Capture, compare and modulator share one hold value
  always_comb begin
    st_nxt          = st_r;
    st_nxt.event_p  = 1'b0;
    st_nxt.pin_prev = lnk.pin_in;
    rise    = lnk.pin_in & ~st_r.pin_prev;                          // RULE_02
    fall    = ~lnk.pin_in & st_r.pin_prev;                          // RULE_02
    cap_hit = (rise & lnk.mode[RISE_BIT]) | (fall & lnk.mode[FALL_BIT]); // RULE_04
    match   = lnk.mode[CMP_EN_BIT] & lnk.fresh & (lnk.count == st_r.hold); // RULE_06
    pwm_on  = lnk.mode[PWM_BIT] & lnk.mode[CMP_EN_BIT];             // RULE_09
    wrap    = lnk.fresh & (lnk.count[7:0] == 8'h00);
    if (lnk.wr_lo) begin
      st_nxt.hold[7:0] = lnk.wdata;                                 // RULE_01 RULE_12
    end
    if (lnk.wr_hi) begin
      st_nxt.hold[15:8] = lnk.wdata;                                // RULE_01 RULE_12
    end
    // A capture beats a same-cycle software write
    if (cap_hit) begin
      st_nxt.hold    = lnk.count;                                   // RULE_03
      st_nxt.event_p = 1'b1;                                        // RULE_05 RULE_17
    end
    if (match && lnk.mode[MATCH_BIT] && !pwm_on) begin
      st_nxt.event_p = 1'b1;                                        // RULE_07 RULE_17
      if (lnk.mode[TOGGLE_BIT]) begin
        st_nxt.pin_out = ~st_r.pin_out;                             // RULE_08
      end
    end
    // Reload on wrap so a duty change lands on a period edge
    duty = wrap ? st_nxt.hold[15:8] : st_nxt.hold[7:0];
    if (pwm_on) begin
      if (wrap) begin
        st_nxt.hold[7:0] = st_nxt.hold[15:8];                       // RULE_11
      end
      st_nxt.pin_out = (lnk.count[7:0] >= duty);                    // RULE_10 RULE_13
    end
    st_nxt.drive = pwm_on |
                   (lnk.mode[TOGGLE_BIT] & lnk.mode[MATCH_BIT] & lnk.mode[CMP_EN_BIT]); // RULE_18
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_r <= '{hold: HOLD_RST, pin_prev: PIN_RST, pin_out: PIN_RST, drive: 1'b0, event_p: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.hold    = st_r.hold;
  assign lnk.event_p = st_r.event_p;
  assign lnk.pin_out = st_r.pin_out;
  assign lnk.drive   = st_r.drive;

endmodule

// [hdl/counter_array_modules.sv]
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module counter_array_modules
  import cca_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire logic [4:0]         addr_i,
  input  wire logic [7:0]         wr_data_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [7:0]         rd_data_o,
  input  wire logic               idle_i,
  input  wire logic               t0_ovf_i,
  input  wire logic               external_count_in_i,
  input  wire logic [NUM_MOD-1:0] module_io_pin_i,
  output logic      [NUM_MOD-1:0] module_io_pin_o,
  output logic      [NUM_MOD-1:0] module_io_pin_oe_n_o,
  output logic                    irq_o
);

  typedef struct packed {
    logic [7:0]                counter_mode;
    logic                      run;
    logic                      ovf_flag;
    logic [NUM_MOD-1:0]        ev_flags;
    logic [15:0]               count;
    logic                      fresh;
    logic [NUM_MOD:0]          ien;
    logic [NUM_MOD-1:0][7:0]   mmode;
    logic [7:0]                rd_data;
    logic [NUM_MOD-1:0]        pin_o;
    logic [NUM_MOD-1:0]        pin_oe_n;
    logic                      irq;
  } top_state_t;

  top_state_t               st_r;
  top_state_t               st_nxt;
  logic                     tick_w;
  logic                     run_w;
  logic [NUM_MOD-1:0]       ev_w;
  logic [NUM_MOD-1:0]       pin_w;
  logic [NUM_MOD-1:0]       drv_w;
  logic [NUM_MOD-1:0][15:0] hold_w;
  logic [NUM_MOD:0]         status_w;
  logic [NUM_MOD:0]         doc_en_w;
  logic                     wr_mode;
  logic                     wr_ctrl;
  logic                     wr_cnt_lo;
  logic                     wr_cnt_hi;
  logic                     wr_clr;
  logic                     wr_ien;

  // Register write decode
  assign wr_mode   = wr_i & (addr_i == ADDR_MODE);
  assign wr_ctrl   = wr_i & (addr_i == ADDR_CTRL);
  assign wr_cnt_lo = wr_i & (addr_i == ADDR_CNT_LO);
  assign wr_cnt_hi = wr_i & (addr_i == ADDR_CNT_HI);
  assign wr_clr    = wr_i & (addr_i == ADDR_CLR);
  assign wr_ien    = wr_i & (addr_i == ADDR_IEN);

  // Idle freezes the counter only when the idle stop bit asks for it
  assign run_w = st_r.run & ~(idle_i & st_r.counter_mode[IDLE_STOP_BIT]); // RULE_15

  count_source u_src (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .sel_i    (st_r.counter_mode[SRC_HI_BIT:SRC_LO_BIT]),
    .run_i    (run_w),
    .t0_ovf_i (t0_ovf_i),
    .ext_i    (external_count_in_i),
    .tick_o   (tick_w)
  );

  // One unit per module, all fed the same counter value
  for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
    localparam logic [4:0] A_LO    = 5'(ADDR_HOLD + 2 * g);
    localparam logic [4:0] A_HI    = 5'(ADDR_HOLD + 2 * g + 1);

    cc_link_if lnk ();

    assign lnk.mode   = st_r.mmode[g];
    assign lnk.count  = st_r.count;                 // RULE_13
    assign lnk.fresh  = st_r.fresh;
    assign lnk.pin_in = module_io_pin_i[g];
    assign lnk.wr_lo  = wr_i & (addr_i == A_LO);    // RULE_12
    assign lnk.wr_hi  = wr_i & (addr_i == A_HI);    // RULE_12
    assign lnk.wdata  = wr_data_i;
    assign ev_w[g]    = lnk.event_p;
    assign pin_w[g]   = lnk.pin_out;
    assign drv_w[g]   = lnk.drive;
    assign hold_w[g]  = lnk.hold;

    capture_compare_unit u_unit (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .lnk     (lnk)
    );

    assign doc_en_w[g] = st_r.mmode[g][MOD_IEN_BIT];
  end

  assign doc_en_w[STAT_OVF_BIT] = st_r.counter_mode[OVF_IEN_BIT];
  assign status_w               = {st_r.ovf_flag, st_r.ev_flags};

  // Register file, shared counter and flags
  always_comb begin
    st_nxt         = st_r;
    st_nxt.fresh   = tick_w;
    st_nxt.rd_data = 8'h00;

    // Configuration writes
    if (wr_mode) begin
      st_nxt.counter_mode = wr_data_i & MODE_VALID;
    end
    if (wr_ien) begin
      st_nxt.ien = wr_data_i[NUM_MOD:0];
    end
    for (int n = 0; n < NUM_MOD; n++) begin
      if (wr_i && addr_i == 5'(ADDR_MMODE + n)) begin
        st_nxt.mmode[n] = wr_data_i & MMODE_VALID;
      end
    end

    // Software may write the flags either way; clear register drops set bits
    if (wr_ctrl) begin
      st_nxt.run      = wr_data_i[RUN_BIT];                         // RULE_15
      st_nxt.ovf_flag = wr_data_i[OVF_FLAG_BIT];                    // RULE_16
      st_nxt.ev_flags = wr_data_i[NUM_MOD-1:0];                     // RULE_17
    end
    if (wr_clr) begin
      st_nxt.ovf_flag = st_r.ovf_flag & ~wr_data_i[STAT_OVF_BIT];   // RULE_16
      st_nxt.ev_flags = st_r.ev_flags & ~wr_data_i[NUM_MOD-1:0];    // RULE_17
    end

    // Counter steps on a source tick; overflow at all ones
    if (tick_w) begin
      st_nxt.count = st_r.count + 16'h0001;                         // RULE_13
      if (st_r.count == 16'hFFFF) begin
        st_nxt.ovf_flag = 1'b1;                                     // RULE_16
      end
    end
    // A byte write wins over a same-cycle count step
    if (wr_cnt_lo) begin
      st_nxt.count[7:0] = wr_data_i;
    end
    if (wr_cnt_hi) begin
      st_nxt.count[15:8] = wr_data_i;
    end

    // Hardware sets last so an event is never lost to a clear
    st_nxt.ev_flags = st_nxt.ev_flags | ev_w;                       // RULE_17

    // One-cycle read data
    if (rd_i) begin
      unique case (addr_i)
        ADDR_MODE:   st_nxt.rd_data = st_r.counter_mode;
        ADDR_CTRL:   st_nxt.rd_data = {st_r.ovf_flag, st_r.run, 1'b0, st_r.ev_flags};
        ADDR_CNT_LO: st_nxt.rd_data = st_r.count[7:0];
        ADDR_CNT_HI: st_nxt.rd_data = st_r.count[15:8];
        ADDR_STAT:   st_nxt.rd_data = {2'b00, status_w};
        ADDR_IEN:    st_nxt.rd_data = {2'b00, st_r.ien};
        default: begin
          for (int n = 0; n < NUM_MOD; n++) begin
            if (addr_i == 5'(ADDR_MMODE + n)) begin
              st_nxt.rd_data = st_r.mmode[n];
            end
            if (addr_i == 5'(ADDR_HOLD + 2 * n)) begin
              st_nxt.rd_data = hold_w[n][7:0];
            end
            if (addr_i == 5'(ADDR_HOLD + 2 * n + 1)) begin
              st_nxt.rd_data = hold_w[n][15:8];
            end
          end
        end
      endcase
    end

    // Pins: released unless a unit is in an output mode
    st_nxt.pin_o    = pin_w;
    st_nxt.pin_oe_n = ~drv_w;                                       // RULE_18

    // Flag must be set, its own enable set, and unmasked
    st_nxt.irq = |(status_w & doc_en_w & st_r.ien);                 // RULE_05 RULE_07 RULE_16
  end

  // Synchronous reset to documented idle state
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_r              <= '0;
      st_r.counter_mode <= MODE_RST;
      st_r.count        <= COUNT_RST;
      st_r.ien          <= IEN_RST;
      st_r.mmode        <= {NUM_MOD{MMODE_RST}};
      st_r.pin_o        <= {NUM_MOD{PIN_RST}};
      st_r.pin_oe_n     <= {NUM_MOD{1'b1}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign rd_data_o            = st_r.rd_data;
  assign module_io_pin_o      = st_r.pin_o;
  assign module_io_pin_oe_n_o = st_r.pin_oe_n;
  assign irq_o                = st_r.irq;

endmodule

// [sim/counter_array_modules_props.sv]
`timescale 1ns/1ps
module counter_array_modules_props
  import cca_pkg::*;
(
  input wire logic               clock_i,
  input wire logic               rst_n_i,
  input wire logic [4:0]         addr_i,
  input wire logic [7:0]         wr_data_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [7:0]         rd_data_o,
  input wire logic               idle_i,
  input wire logic               t0_ovf_i,
  input wire logic               external_count_in_i,
  input wire logic [NUM_MOD-1:0] module_io_pin_i,
  input wire logic [NUM_MOD-1:0] module_io_pin_o,
  input wire logic [NUM_MOD-1:0] module_io_pin_oe_n_o,
  input wire logic               irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Pins parked high and undriven, no request, right after reset
  AST_RESET_OUT: assert property ($rose(rst_n_i) |-> module_io_pin_o == '1 && module_io_pin_oe_n_o == '1 && !irq_o)
    else $error("outputs not in reset state");
  // Read data only in the answer cycle
  AST_READ_IDLE: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside answer cycle");
  AST_UNMAPPED: assert property (rd_i && (addr_i == 5'h07 || addr_i > 5'h19) |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  // Written values read back through their masks
  AST_MODE_MASK: assert property (
    wr_i && addr_i == ADDR_MODE ##2 rd_i && addr_i == ADDR_MODE |=> rd_data_o == ($past(wr_data_i, 3) & MODE_VALID))
    else $error("counter mode readback wrong");
  AST_MMODE_MASK: assert property (
    wr_i && addr_i inside {[ADDR_MMODE:ADDR_MMODE + 5'h04]} ##2 rd_i && addr_i == $past(addr_i, 2)
    |=> rd_data_o == ($past(wr_data_i, 3) & MMODE_VALID))
    else $error("module mode readback wrong");
  AST_IEN_MASK: assert property (
    wr_i && addr_i == ADDR_IEN ##2 rd_i && addr_i == ADDR_IEN |=> rd_data_o == ($past(wr_data_i, 3) & 8'h3F))
    else $error("enable mask readback wrong");
  // A cleared mask silences the request two cycles on
  AST_IRQ_MASKED: assert property (wr_i && addr_i == ADDR_IEN && wr_data_i == 8'h00 |=> ##1 !irq_o)
    else $error("interrupt despite cleared mask");
  AST_CTRL_SPARE: assert property (rd_i && addr_i == ADDR_CTRL |=> !rd_data_o[5])
    else $error("spare control bit reads one");
endmodule

bind counter_array_modules counter_array_modules_props i_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .idle_i(idle_i), .t0_ovf_i(t0_ovf_i),
  .external_count_in_i(external_count_in_i), .module_io_pin_i(module_io_pin_i),
  .module_io_pin_o(module_io_pin_o), .module_io_pin_oe_n_o(module_io_pin_oe_n_o), .irq_o(irq_o));

// [sim/pin_partner.sv]
`timescale 1ns/1ps
module pin_partner (
  input  wire logic       clock_i,
  input  wire logic       gen_i,
  output logic      [4:0] pin_o,
  output logic            t0_ovf_o,
  output logic            ext_o
);
  logic [1:0] ph_r  = 2'h0;
  logic [2:0] div_r = 3'h0;

  initial begin
    pin_o = 5'h00;
    t0_ovf_o = 1'b0;
    ext_o = 1'b1;
  end

  // Overflow every third clock; external falls every eighth, slower than the input allows (it can count a fall every second clock)
  always @(posedge clock_i) begin
    ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    div_r <= div_r + 3'h1;
    t0_ovf_o <= gen_i && ph_r == 2'h2;
    ext_o <= gen_i ? div_r[2] : 1'b1;
  end

  // Pin levels move just after a rising edge
  task automatic set_pins(input logic [4:0] v);
    @(posedge clock_i);
    pin_o <= v;
  endtask
endmodule

// [sim/test_counter_array_modules.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_counter_array_modules;
  import cca_pkg::*;
  logic        clock_i   = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        gen       = 1'b0;
  logic        idle      = 1'b0;
  logic [4:0]  addr_i    = 5'h00;
  logic [7:0]  wr_data_i = 8'h00;
  logic [7:0]  rd_data_o, q, d, d0;
  logic [4:0]  pin_i, pin_o, oe_n;
  logic        t0, ext, irq_o;
  logic [15:0] c, h;
  logic [7:0]  pl[4];
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          k;

  always #5 clock_i = ~clock_i;

  // Device under test; idle level comes from the bench
  counter_array_modules i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .idle_i(idle), .t0_ovf_i(t0),
    .external_count_in_i(ext), .module_io_pin_i(pin_i), .module_io_pin_o(pin_o),
    .module_io_pin_oe_n_o(oe_n), .irq_o(irq_o));
  pin_partner i_pins (.clock_i(clock_i), .gen_i(gen), .pin_o(pin_i), .t0_ovf_o(t0), .ext_o(ext));

  // Bus cycles start at a rising edge and release after the sampling edge
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    v = rd_data_o;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  task automatic wr16(input logic [4:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 5'h01, v[15:8]);
  endtask
  task automatic chkh(input logic [4:0] n, input logic [15:0] e);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(ADDR_HOLD + (n << 1), lo);
    rd(ADDR_HOLD + (n << 1) + 5'h01, hi);
    `CHK({hi, lo}, e)
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // Counts expected from each source over 48 clocks
  function automatic int ticks(input int s);
    case (s)
      0: return 48 / (DIV12_LAST + 1);
      1: return 48 / (DIV4_LAST + 1);
      2: return 16;
      default: return 6;
    endcase
  endfunction

  task automatic results;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(4583));
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // Reset values, masks and unmapped places
    rdc(ADDR_MODE, MODE_RST);
    `CHK(pin_o & oe_n, 5'h1F)
    wr(ADDR_MODE, 8'hFF);
    rdc(ADDR_MODE, MODE_VALID);
    wr(ADDR_MMODE + 5'h04, 8'hFF);
    rdc(ADDR_MMODE + 5'h04, MMODE_VALID);
    wr(ADDR_IEN, 8'hFF);
    rdc(ADDR_IEN, 8'h3F);
    rdc(5'h07, 8'h00);
    rdc(5'h1F, 8'h00);
    wr(ADDR_MMODE + 5'h04, 8'h00);
    wr(ADDR_MODE, 8'h00);
    // Capture: rising on 0, falling on 1, both on 2; 3 and 4 idle
    wr(ADDR_IEN, 8'h01);
    wr(ADDR_MMODE, 8'h21);
    wr(ADDR_MMODE + 5'h01, 8'h10);
    wr(ADDR_MMODE + 5'h02, 8'h30);
    c = 16'($urandom);
    wr16(ADDR_CNT_LO, c);
    i_pins.set_pins(5'h1F);
    pause(6);
    `CHK(irq_o, 1'b1)
    `CHK(pin_o, 5'h1F)
    rdc(ADDR_STAT, 8'h05);
    chkh(5'h00, c);
    chkh(5'h01, HOLD_RST);
    chkh(5'h02, c);
    h = 16'($urandom);
    wr16(ADDR_CNT_LO, h);
    i_pins.set_pins(5'h00);
    pause(6);
    rdc(ADDR_STAT, 8'h07);
    chkh(5'h00, c);
    chkh(5'h01, h);
    chkh(5'h02, h);
    // Interrupt masked, unmasked, then flags cleared
    wr(ADDR_IEN, 8'h00);
    pause(3);
    `CHK(irq_o, 1'b0)
    wr(ADDR_IEN, 8'h01);
    pause(3);
    `CHK(irq_o, 1'b1)
    wr(ADDR_CLR, 8'h07);
    pause(3);
    `CHK(irq_o, 1'b0)
    rdc(ADDR_STAT, 8'h00);
    // Timer on 2, toggling output on 3, counting from zero at clock/4
    h = 16'h0010 + 16'($urandom_range(0, 15));
    wr(ADDR_MMODE, 8'h00);
    wr(ADDR_MMODE + 5'h01, 8'h00);
    wr(ADDR_MMODE + 5'h02, 8'h48);
    wr(ADDR_MMODE + 5'h03, 8'h4D);
    wr16(ADDR_HOLD + 5'h04, h);
    wr16(ADDR_HOLD + 5'h06, h);
    chkh(5'h03, h);
    wr16(ADDR_CNT_LO, COUNT_RST);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_IEN, 8'h08);
    wr(ADDR_CTRL, 8'h40);
    k = 0;
    while (pin_o[3] !== 1'b0 && k < 400) begin
      @(negedge clock_i);
      k++;
    end
    `CHK(k < 400, 1'b1)
    if (k >= 400) results();
    `CHK(pin_o[2], 1'b1)
    `CHK(oe_n, 5'h17)
    pause(3);
    `CHK(irq_o, 1'b1)
    rdc(ADDR_STAT, 8'h0C);
    wr(ADDR_CTRL, 8'h00);
    // Two modulated outputs with own duty; module 1 lacks compare enable
    d = 8'($urandom_range(8'h40, 8'hBF));
    d0 = d + 8'h20;
    wr(ADDR_MMODE + 5'h02, 8'h00);
    wr(ADDR_MMODE + 5'h03, 8'h00);
    wr(ADDR_MMODE, 8'h42);
    wr(ADDR_MMODE + 5'h01, 8'h02);
    wr(ADDR_MMODE + 5'h04, 8'h42);
    wr(ADDR_HOLD + 5'h01, d0);
    wr(ADDR_HOLD + 5'h03, 8'hFF);
    wr(ADDR_HOLD + 5'h09, d);
    wr16(ADDR_CNT_LO, 16'h00FE);
    wr(ADDR_CTRL, 8'h40);
    pause(20);
    wr(ADDR_CTRL, 8'h00);
    pl = '{d - 8'h01, d, d0 - 8'h01, d0};
    foreach (pl[i]) begin
      wr(ADDR_CNT_LO, pl[i]);
      pause(4);
      `CHK(pin_o[4], pl[i] >= d)
      `CHK(pin_o[0], pl[i] >= d0)
      `CHK(pin_o[1], 1'b1)
      `CHK(oe_n, 5'h0E)
      `CHK(pin_o[4] & ~pin_o[0], pl[i] >= d && pl[i] < d0)
    end
    // Overflow flag and its interrupt
    wr16(ADDR_CNT_LO, 16'hFFFF);
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_IEN, 8'h20);
    wr(ADDR_CTRL, 8'h40);
    pause(12);
    rdc(ADDR_CTRL, 8'hC0);
    `CHK(irq_o, 1'b1)
    wr(ADDR_CTRL, 8'h00);
    gen <= 1'b1;
    pause(3);
    `CHK(irq_o, 1'b0)
    // Every count source; counter frozen once stopped
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_MODE, {5'h00, 2'(s), 1'b0});
      wr16(ADDR_CNT_LO, COUNT_RST);
      wr(ADDR_CTRL, 8'h40);
      repeat (48) @(posedge clock_i);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CNT_LO, q);
      `CHK(q >= ticks(s) - 1 && q <= ticks(s) + 2, 1'b1)
      pause(20);
      rdc(ADDR_CNT_LO, q);
    end
    // Idle with the stop bit set holds the counter although run is set
    wr(ADDR_MODE, 8'h82);
    idle <= 1'b1;
    wr(ADDR_CTRL, 8'h40);
    pause(20);
    rdc(ADDR_CNT_LO, q);
    results();
  end
endmodule
